// ### scs_pkg.sv
// scs_pkg: constants, register map and state type of the second serial controller (spi side).
// assumes: apb slave with 32-bit data; each register index maps to byte address index*4.
package scs_pkg;

    // ----------------------------------------------------------------
    // register indices and byte addresses
    // ----------------------------------------------------------------
    localparam logic [15:0] IDX_DATA   = 16'h441e;
    localparam logic [15:0] IDX_STAT   = 16'h4420;
    localparam logic [15:0] IDX_MODE   = 16'h442a;
    localparam logic [15:0] IDX_CFG    = 16'h442c;
    localparam logic [15:0] IDX_LIN    = 16'h4430;
    localparam logic [15:0] IDX_EXP    = 16'h4432;
    localparam logic [31:0] ADDR_DATA  = {14'h0000, IDX_DATA, 2'h0};
    localparam logic [31:0] ADDR_STAT  = {14'h0000, IDX_STAT, 2'h0};
    localparam logic [31:0] ADDR_MODE  = {14'h0000, IDX_MODE, 2'h0};
    localparam logic [31:0] ADDR_CFG   = {14'h0000, IDX_CFG, 2'h0};
    localparam logic [31:0] ADDR_LIN   = {14'h0000, IDX_LIN, 2'h0};
    localparam logic [31:0] ADDR_EXP   = {14'h0000, IDX_EXP, 2'h0};

    // ----------------------------------------------------------------
    // fields and reset values
    // ----------------------------------------------------------------
    localparam int          CFG_POL    = 0;
    localparam int          CFG_PHA    = 1;
    localparam int          CFG_ORD    = 2;
    localparam int          CFG_RPT    = 3;
    localparam int          CFG_MST    = 4;
    localparam int          CFG_RXDRV  = 5;
    localparam int          STAT_OVF   = 0;
    localparam int          STAT_RXVAL = 1;
    localparam int          STAT_FREE  = 2;
    localparam int          STAT_IDLE  = 3;
    localparam logic [1:0]  MODE_RST   = 2'h0;
    localparam logic [5:0]  CFG_RST    = 6'h00;
    localparam logic [3:0]  LIN_RST    = 4'h0;
    localparam logic [3:0]  EXP_RST    = 4'h0;
    localparam logic [1:0]  MODE_SPI   = 2'h2;
    localparam logic [1:0]  MODE_TWI   = 2'h3;
    localparam logic [7:0]  FILL_BYTE  = 8'hff;

    // ----------------------------------------------------------------
    // fifo and frame sizes
    // ----------------------------------------------------------------
    localparam int          FIFO_AW    = 2;
    localparam int          FIFO_DEPTH = 4;
    localparam logic [3:0]  LAST_EDGE  = 4'hf;

    typedef enum logic [1:0] {
        SCS_IDLE  = 2'b01,
        SCS_SHIFT = 2'b10
    } scs_state_t;

endpackage

// ### scs_rate_if.sv
// scs_rate_if: link between the controller and its serial rate divider.
// assumes: one clock domain, pclk.
`timescale 1ns/1ns
interface scs_rate_if;
    logic       run;
    logic [3:0] rate_linear_factor;
    logic [3:0] exponent_factor;
    logic       tick;

    modport ctrl (output run, output rate_linear_factor, output exponent_factor, input tick);
    modport gen  (input run, input rate_linear_factor, input exponent_factor, output tick);
endinterface

// ### scs_rate_gen.sv
// scs_rate_gen: serial clock half-period divider, one tick per half period.
// assumes: pclk stands in as the rate reference; run held high for a whole frame.
`timescale 1ns/1ns
module scs_rate_gen (
    input  wire logic pclk,
    input  wire logic presetn,
    scs_rate_if.gen   rate
);

    logic [19:0] half_count;
    logic [19:0] cnt_reg;
    logic        tick_reg;
    wire         at_end;

    // half period = (lin + 1) * 2^exp cycles
    assign half_count = 20'(({16'h0000, rate.rate_linear_factor} + 20'h00001)
                        << rate.exponent_factor);
    assign at_end     = (cnt_reg == half_count - 20'h00001);
    assign rate.tick  = tick_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg  <= 20'h00000;
            tick_reg <= 1'b0;
        end else if (!rate.run) begin
            cnt_reg  <= 20'h00000;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= at_end ? 20'h00000 : cnt_reg + 20'h00001;
            tick_reg <= at_end;
        end
    end

endmodule // scs_rate_gen

// ### scs_top.sv
// scs_top: apb registers, byte fifos and spi master/slave engine of the serial controller.
// assumes: apb master per amba; serial pins synchronous to pclk; pad logic resolves enables.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
module scs_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             sclk_o,
    output logic             sclk_oe_n,
    input  wire logic        sclk_i,
    output logic             mosi_o,
    output logic             mosi_oe_n,
    input  wire logic        mosi_i,
    output logic             miso_o,
    output logic             miso_oe_n,
    input  wire logic        miso_i,
    output logic             ssel_n_o,
    output logic             ssel_n_oe_n,
    input  wire logic        ssel_n_i
);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [1:0]  mode_reg;
    logic [5:0]  cfg_reg;
    logic [3:0]  lin_reg;
    logic [3:0]  exp_reg;
    logic        ovf_reg;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;

    // ----------------------------------------------------------------
    // fifo storage
    // ----------------------------------------------------------------
    logic [7:0]  tx_mem [scs_pkg::FIFO_DEPTH];
    logic [7:0]  rx_mem [scs_pkg::FIFO_DEPTH];
    logic [2:0]  tx_wp_reg;
    logic [2:0]  tx_rp_reg;
    logic [2:0]  rx_wp_reg;
    logic [2:0]  rx_rp_reg;

    // ----------------------------------------------------------------
    // engine state
    // ----------------------------------------------------------------
    scs_pkg::scs_state_t state_reg;
    logic [3:0]  edge_reg;
    logic [7:0]  tx_sr_reg;
    logic [7:0]  rx_sr_reg;
    logic [7:0]  last_reg;
    logic        out_bit_reg;
    logic        sclk_reg;
    logic        sclk_prev_reg;
    logic        ssel_n_reg;
    logic        mst_oe_n_reg;
    logic        slv_oe_n_reg;

    scs_rate_if rate_if ();

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire req      = psel & penable & ~pready_reg;
    wire wr_req   = req & pwrite;
    wire rd_req   = req & ~pwrite;
    wire hit_data = (paddr == scs_pkg::ADDR_DATA);
    wire hit_stat = (paddr == scs_pkg::ADDR_STAT);
    wire hit_mode = (paddr == scs_pkg::ADDR_MODE);
    wire hit_cfg  = (paddr == scs_pkg::ADDR_CFG);
    wire hit_lin  = (paddr == scs_pkg::ADDR_LIN);
    wire hit_exp  = (paddr == scs_pkg::ADDR_EXP);
    wire hit_any  = hit_data | hit_stat | hit_mode | hit_cfg | hit_lin | hit_exp;

    // ----------------------------------------------------------------
    // fifo flags
    // ----------------------------------------------------------------
    wire tx_empty = (tx_wp_reg == tx_rp_reg);
    wire tx_full  = (tx_wp_reg == {~tx_rp_reg[2], tx_rp_reg[1:0]});
    wire rx_empty = (rx_wp_reg == rx_rp_reg);
    wire rx_full  = (rx_wp_reg == {~rx_rp_reg[2], rx_rp_reg[1:0]});
    wire [7:0] tx_head = tx_mem[tx_rp_reg[1:0]];
    wire [7:0] rx_head = rx_mem[rx_rp_reg[1:0]];

    // ----------------------------------------------------------------
    // configuration decode
    // ----------------------------------------------------------------
    wire spi_on   = (mode_reg == scs_pkg::MODE_SPI);
    wire master   = cfg_reg[scs_pkg::CFG_MST];
    wire cpol     = cfg_reg[scs_pkg::CFG_POL];
    wire cpha     = cfg_reg[scs_pkg::CFG_PHA];
    wire lsb_1st  = cfg_reg[scs_pkg::CFG_ORD];
    wire repeat_b = cfg_reg[scs_pkg::CFG_RPT];
    wire rx_drv   = cfg_reg[scs_pkg::CFG_RXDRV];
    wire idle     = (state_reg == scs_pkg::SCS_IDLE);
    wire shifting = (state_reg == scs_pkg::SCS_SHIFT);

    // ----------------------------------------------------------------
    // frame start and byte selection
    // ----------------------------------------------------------------
    wire mst_go   = rx_drv ? ~rx_full : ~tx_empty;
    wire start    = idle & spi_on & (master ? mst_go : ~ssel_n_i);
    wire [7:0] fill_byte = repeat_b ? last_reg : scs_pkg::FILL_BYTE;
    wire [7:0] load_byte = tx_empty ? fill_byte : tx_head;
    wire tx_pop   = start & ~tx_empty;

    // ----------------------------------------------------------------
    // serial edges
    // ----------------------------------------------------------------
    wire slv_edge = ~master & ~ssel_n_i & (sclk_i != sclk_prev_reg);
    wire edge_ev  = shifting & (master ? rate_if.tick : slv_edge);
    wire leading  = ~edge_reg[0];
    wire smp_ev   = edge_ev & (leading != cpha);
    wire drv_ev   = edge_ev & (leading == cpha) & ~(~cpha & (edge_reg == scs_pkg::LAST_EDGE));
    wire done     = edge_ev & (edge_reg == scs_pkg::LAST_EDGE);
    wire abort    = shifting & (~spi_on | (~master & ssel_n_i));
    wire in_bit   = master ? miso_i : mosi_i;
    wire [7:0] rx_next = lsb_1st ? {in_bit, rx_sr_reg[7:1]} : {rx_sr_reg[6:0], in_bit};
    wire rx_push  = done & ~rx_full;
    wire rx_lost  = done & rx_full;
    wire rx_pop   = rd_req & hit_data & ~rx_empty;

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    wire [3:0]  stat_v = {idle & tx_empty, ~tx_full, ~rx_empty, ovf_reg};
    wire [31:0] rd_mux = hit_data ? {24'h000000, rx_empty ? 8'h00 : rx_head}
                       : hit_stat ? {28'h0000000, stat_v}
                       : hit_mode ? {30'h00000000, mode_reg}
                       : hit_cfg  ? {26'h0000000, cfg_reg}
                       : hit_lin  ? {28'h0000000, lin_reg}
                       : hit_exp  ? {28'h0000000, exp_reg}
                       : 32'h00000000;

    // ----------------------------------------------------------------
    // bit order helpers
    // ----------------------------------------------------------------
    function automatic logic first_bit(input logic [7:0] b, input logic lsb);
        first_bit = lsb ? b[0] : b[7];
    endfunction

    function automatic logic [7:0] shift_on(input logic [7:0] b, input logic lsb);
        shift_on = lsb ? {1'b0, b[7:1]} : {b[6:0], 1'b0};
    endfunction

    // ----------------------------------------------------------------
    // rate divider
    // ----------------------------------------------------------------
    assign rate_if.run                = master & shifting & spi_on;
    assign rate_if.rate_linear_factor = lin_reg;
    assign rate_if.exponent_factor    = exp_reg;

    scs_rate_gen u_rate (
        .pclk    (pclk),
        .presetn (presetn),
        .rate    (rate_if.gen)
    );

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h00000000;
        end else begin
            pready_reg  <= req;
            pslverr_reg <= req & ~hit_any;
            if (req) begin
                prdata_reg <= rd_mux;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= scs_pkg::MODE_RST;
            cfg_reg  <= scs_pkg::CFG_RST;
            lin_reg  <= scs_pkg::LIN_RST;
            exp_reg  <= scs_pkg::EXP_RST;
        end else if (wr_req) begin
            if (hit_mode) mode_reg <= pwdata[1:0];
            if (hit_cfg)  cfg_reg  <= pwdata[5:0];
            if (hit_lin)  lin_reg  <= pwdata[3:0];
            if (hit_exp)  exp_reg  <= pwdata[3:0];
        end
    end

    // overflow is sticky; a new loss wins over the clearing read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_reg <= 1'b0;
        end else begin
            ovf_reg <= rx_lost | (ovf_reg & ~(rd_req & hit_data));
        end
    end

    // ----------------------------------------------------------------
    // fifos
    // ----------------------------------------------------------------
    always_ff @(posedge pclk) begin
        if (wr_req & hit_data & ~tx_full) begin
            tx_mem[tx_wp_reg[1:0]] <= pwdata[7:0];
        end
        if (rx_push) begin
            rx_mem[rx_wp_reg[1:0]] <= cpha ? rx_next : rx_sr_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_wp_reg <= 3'h0;
            tx_rp_reg <= 3'h0;
            rx_wp_reg <= 3'h0;
            rx_rp_reg <= 3'h0;
        end else begin
            if (wr_req & hit_data & ~tx_full) tx_wp_reg <= tx_wp_reg + 3'h1;
            if (tx_pop)                       tx_rp_reg <= tx_rp_reg + 3'h1;
            if (rx_push)                      rx_wp_reg <= rx_wp_reg + 3'h1;
            if (rx_pop)                       rx_rp_reg <= rx_rp_reg + 3'h1;
        end
    end

    // ----------------------------------------------------------------
    // frame engine
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg   <= scs_pkg::SCS_IDLE;
            edge_reg    <= 4'h0;
            tx_sr_reg   <= 8'h00;
            rx_sr_reg   <= 8'h00;
            last_reg    <= 8'h00;
            out_bit_reg <= 1'b0;
        end else begin
            case (state_reg)
                scs_pkg::SCS_IDLE: begin
                    if (start) begin
                        state_reg <= scs_pkg::SCS_SHIFT;
                        edge_reg  <= 4'h0;
                        last_reg  <= load_byte;
                        if (!cpha) begin
                            out_bit_reg <= first_bit(load_byte, lsb_1st);
                            tx_sr_reg   <= shift_on(load_byte, lsb_1st);
                        end else begin
                            tx_sr_reg   <= load_byte;
                        end
                    end
                end
                scs_pkg::SCS_SHIFT: begin
                    if (abort || done) begin
                        state_reg <= scs_pkg::SCS_IDLE;
                    end
                    if (edge_ev) begin
                        edge_reg <= edge_reg + 4'h1;
                    end
                    if (smp_ev) begin
                        rx_sr_reg <= rx_next;
                    end
                    if (drv_ev) begin
                        out_bit_reg <= first_bit(tx_sr_reg, lsb_1st);
                        tx_sr_reg   <= shift_on(tx_sr_reg, lsb_1st);
                    end
                end
                default: begin
                    state_reg <= scs_pkg::SCS_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pin drivers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_reg      <= 1'b0;
            sclk_prev_reg <= 1'b0;
            ssel_n_reg    <= 1'b1;
            mst_oe_n_reg  <= 1'b1;
            slv_oe_n_reg  <= 1'b1;
        end else begin
            sclk_prev_reg <= sclk_i;
            mst_oe_n_reg  <= ~(spi_on & master);
            slv_oe_n_reg  <= ~(spi_on & ~master & ~ssel_n_i);
            ssel_n_reg    <= ~(master & spi_on & (start | (shifting & ~done & ~abort)));
            if (shifting && master && edge_ev && !done) begin
                sclk_reg <= ~sclk_reg;
            end else if (!shifting || done || abort) begin
                sclk_reg <= cpol;
            end
        end
    end

    assign prdata      = prdata_reg;
    assign pready      = pready_reg;
    assign pslverr     = pslverr_reg;
    assign sclk_o      = sclk_reg;
    assign sclk_oe_n   = mst_oe_n_reg;
    assign mosi_o      = out_bit_reg;
    assign mosi_oe_n   = mst_oe_n_reg;
    assign miso_o      = out_bit_reg;
    assign miso_oe_n   = slv_oe_n_reg;
    assign ssel_n_o    = ssel_n_reg;
    assign ssel_n_oe_n = mst_oe_n_reg;

endmodule // scs_top

// ### scs_props.sv
// scs_props: port checks of the serial controller.
// assumes: bound onto scs_top; one clock domain, pclk.
`timescale 1ns/1ns
module scs_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic        sclk_o,
    input wire logic        sclk_oe_n,
    input wire logic        mosi_oe_n,
    input wire logic        miso_oe_n,
    input wire logic        ssel_n_o,
    input wire logic        ssel_n_oe_n
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       sclk_reg;
    logic [4:0] edge_cnt;
    // serial clock edges within one select pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_reg <= 1'b0;
            edge_cnt <= 5'h00;
        end else begin
            sclk_reg <= sclk_o;
            edge_cnt <= ssel_n_o ? 5'h00 : edge_cnt + {4'h0, sclk_o != sclk_reg};
        end
    end
    property p_wait; psel && penable && !pready |=> pready; endproperty
    a_wait: assert property (p_wait) else $error("no answer after one wait state");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
    property p_cause; pready |-> $past(psel) && $past(penable); endproperty
    a_cause: assert property (p_cause) else $error("pready without request");
    property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("bad refused transfer");
    property p_oe_tie; !ssel_n_o |-> !ssel_n_oe_n; endproperty
    a_oe_tie: assert property (p_oe_tie) else $error("select enable split");
    property p_oe_excl; !mosi_oe_n |-> !sclk_oe_n && miso_oe_n; endproperty
    a_oe_excl: assert property (p_oe_excl) else $error("master and slave drive");
    property p_idle; $changed(sclk_o) && !sclk_oe_n && !$past(sclk_oe_n) |-> !$past(ssel_n_o); endproperty
    a_idle: assert property (p_idle) else $error("clock moved outside frame");
    property p_edges; $rose(ssel_n_o) |-> edge_cnt == 5'h0f && sclk_o != sclk_reg; endproperty
    a_edges: assert property (p_edges) else $error("frame edge count wrong");
    property p_hold; $fell(ssel_n_o) |-> !ssel_n_o [*8]; endproperty
    a_hold: assert property (p_hold) else $error("select pulse too short");
    c_frame: cover property ($rose(ssel_n_o));
    c_err: cover property (pslverr);
    c_slave: cover property (!miso_oe_n);
endmodule // scs_props

bind scs_top scs_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .sclk_o(sclk_o), .sclk_oe_n(sclk_oe_n),
    .mosi_oe_n(mosi_oe_n), .miso_oe_n(miso_oe_n), .ssel_n_o(ssel_n_o), .ssel_n_oe_n(ssel_n_oe_n));

// ### scs_peer.sv
// scs_peer: behavioural spi slave at the far end of the link.
// assumes: sclk synchronous to pclk, half period at least two pclk cycles.
`timescale 1ns/1ns
module scs_peer (
    input  wire logic       pclk,
    input  wire logic       sclk,
    input  wire logic       mosi,
    input  wire logic       ssel_n,
    input  wire logic       pha,
    input  wire logic       lsb_first,
    input  wire logic [7:0] tx_byte,
    output logic            miso,
    output logic      [7:0] rx_byte
);
    logic       sclk_reg = 1'b0;
    logic       sel_reg  = 1'b1;
    logic       lead_reg = 1'b1;
    logic [3:0] idx_reg  = 4'h0;
    wire  [2:0] bit_pos  = lsb_first ? idx_reg[2:0] : 3'h7 - idx_reg[2:0];
    initial miso = 1'b0;
    always @(posedge pclk) begin
        sclk_reg <= sclk;
        sel_reg  <= ssel_n;
        if (ssel_n && sel_reg) begin
            // released line shows no stale data
            miso     <= ~miso;
            idx_reg  <= 4'h0;
            lead_reg <= 1'b1;
        end else if (sel_reg) begin
            miso    <= pha ? miso : tx_byte[bit_pos];
            idx_reg <= pha ? 4'h0 : 4'h1;
        end else if (sclk != sclk_reg) begin
            lead_reg <= ~lead_reg;
            if (lead_reg ^ pha) begin
                rx_byte <= lsb_first ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
            end else begin
                miso    <= tx_byte[bit_pos];
                idx_reg <= idx_reg + 4'h1;
            end
        end
    end
endmodule // scs_peer

// ### scs_top_tb.sv
// scs_top_tb: self-checking bench of the serial controller over apb.
// assumes: scs_peer is the spi slave; scs_props bound onto scs_top.
`timescale 1ns/1ns
module scs_top_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic        ssel_n_i = 1'b1;
    logic        pk_pha = 1'b0;
    logic        pk_lsb = 1'b0;
    logic [7:0]  pk_tx = 8'h00;
    logic [7:0]  pk_rx;
    logic [31:0] prdata;
    logic        pready, pslverr, sclk_o, sclk_oe_n, mosi_o, mosi_oe_n;
    logic        miso_o, miso_oe_n, ssel_n_o, ssel_n_oe_n, peer_miso, last_err;
    int          mismatches = 0;
    int          tests_run = 0;
    always #25 pclk = ~pclk;
    scs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sclk_o(sclk_o), .sclk_oe_n(sclk_oe_n), .sclk_i(1'b0), .mosi_o(mosi_o), .mosi_oe_n(mosi_oe_n),
        .mosi_i(1'b0), .miso_o(miso_o), .miso_oe_n(miso_oe_n), .miso_i(peer_miso), .ssel_n_o(ssel_n_o),
        .ssel_n_oe_n(ssel_n_oe_n), .ssel_n_i(ssel_n_i));
    scs_peer peer (.pclk(pclk), .sclk(sclk_o), .mosi(mosi_o), .ssel_n(ssel_n_o), .pha(pk_pha),
        .lsb_first(pk_lsb), .tx_byte(pk_tx), .miso(peer_miso), .rx_byte(pk_rx));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) chk(32'h1, 32'h0);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] r);
        apb(1'b0, a, 32'h0, r);
    endtask
    task automatic wait_frames(input int k);
        int n;
        logic last;
        n = 0;
        last = ssel_n_o;
        while (k > 0 && n < 20000) begin
            @(posedge pclk);
            n++;
            if (ssel_n_o === 1'b1 && last === 1'b0) k--;
            last = ssel_n_o;
        end
        @(posedge pclk);
        if (k > 0) chk(32'h1, 32'h0);
    endtask
    task automatic finish_test;
        $display("TB: %0d checks, %0d mismatches", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        logic [31:0] adr [5] = '{scs_pkg::ADDR_MODE, scs_pkg::ADDR_CFG, scs_pkg::ADDR_LIN,
                                 scs_pkg::ADDR_EXP, scs_pkg::ADDR_STAT};
        logic [31:0] msk [5] = '{32'h3, 32'h3f, 32'hf, 32'hf, 32'hc};
        logic [31:0] r;
        foreach (adr[i]) begin
            rd(adr[i], r);
            chk(r, i == 4 ? 32'hc : 32'h0);
            wr(adr[i], 32'hffff_ffff);
            rd(adr[i], r);
            chk(r, msk[i]);
        end
        for (int i = 0; i < 4; i++) wr(adr[i], 32'h0);
        rd(32'h0000_0000, r);
        chk({r[30:0], last_err}, 32'h1);
        $display("TB: register test done");
    endtask
    task automatic xfer(input logic [5:0] cfg, input logic [3:0] lin, input logic [3:0] ex,
                        input logic [7:0] tx);
        logic [31:0] r;
        int n, t0;
        wr(scs_pkg::ADDR_MODE, 32'h0);
        wr(scs_pkg::ADDR_CFG, {26'h0, cfg});
        wr(scs_pkg::ADDR_LIN, {28'h0, lin});
        wr(scs_pkg::ADDR_EXP, {28'h0, ex});
        pk_pha <= cfg[1];
        pk_lsb <= cfg[2];
        pk_tx <= ~tx;
        wr(scs_pkg::ADDR_DATA, {24'h0, tx});
        wr(scs_pkg::ADDR_MODE, {30'h0, scs_pkg::MODE_SPI});
        n = 0;
        while (sclk_o === cfg[0] && n < 4000) begin @(posedge pclk); n++; end
        t0 = n;
        while (sclk_o !== cfg[0] && n < 4000) begin @(posedge pclk); n++; end
        chk(32'(n - t0), 32'((int'(lin) + 1) << ex));
        wait_frames(1);
        chk({31'h0, sclk_o}, {31'h0, cfg[0]});
        chk({24'h0, pk_rx}, {24'h0, tx});
        rd(scs_pkg::ADDR_DATA, r);
        chk(r, {24'h0, ~tx});
    endtask
    task automatic t_frames;
        logic [7:0] txv [4] = '{8'h1d, 8'hb4, 8'h62, 8'hc9};
        for (int i = 0; i < 4; i++)
            xfer({3'b010, i[1] ^ i[0], i[1], i[0]}, 4'(i + 1), {3'h0, i[0]}, txv[i]);
        $display("TB: frame test done");
    endtask
    task automatic t_modes;
        logic [1:0] mv [3] = '{2'h1, scs_pkg::MODE_TWI, 2'h0};
        logic [31:0] r;
        foreach (mv[i]) begin
            wr(scs_pkg::ADDR_MODE, {30'h0, mv[i]});
            if (i == 0) wr(scs_pkg::ADDR_DATA, 32'h5a);
            repeat (40) @(posedge pclk);
            chk({30'h0, ssel_n_o, sclk_oe_n}, 32'h3);
        end
        wr(scs_pkg::ADDR_MODE, {30'h0, scs_pkg::MODE_SPI});
        wait_frames(1);
        chk({24'h0, pk_rx}, 32'h5a);
        rd(scs_pkg::ADDR_DATA, r);
        chk(r, {24'h0, pk_tx});
        $display("TB: mode test done");
    endtask
    task automatic t_underrun;
        logic [7:0] fill [2] = '{8'h5a, scs_pkg::FILL_BYTE};
        logic [31:0] r;
        for (int k = 0; k < 2; k++) begin
            wr(scs_pkg::ADDR_CFG, k == 0 ? 32'h3b : 32'h33);
            if (k == 1) wr(scs_pkg::ADDR_MODE, {30'h0, scs_pkg::MODE_SPI});
            wait_frames(4);
            chk({24'h0, pk_rx}, {24'h0, fill[k]});
            wr(scs_pkg::ADDR_MODE, 32'h0);
            for (int j = 0; j < 4; j++) begin
                rd(scs_pkg::ADDR_DATA, r);
                chk(r, {24'h0, pk_tx});
            end
        end
        rd(scs_pkg::ADDR_STAT, r);
        chk(r, 32'hc);
        $display("TB: underrun test done");
    endtask
    task automatic t_slave;
        wr(scs_pkg::ADDR_CFG, 32'h0);
        wr(scs_pkg::ADDR_MODE, {30'h0, scs_pkg::MODE_SPI});
        repeat (2) @(posedge pclk);
        chk({30'h0, sclk_oe_n, mosi_oe_n}, 32'h3);
        ssel_n_i <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({30'h0, miso_oe_n, miso_o}, 32'h1);
        ssel_n_i <= 1'b1;
        wr(scs_pkg::ADDR_MODE, 32'h0);
        $display("TB: slave test done");
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_frames();
        t_modes();
        t_underrun();
        t_slave();
        finish_test();
    end
    initial begin
        #(50 * 40000);
        mismatches++;
        finish_test();
    end
endmodule // scs_top_tb
